//--- verilog/uim_uart_irq_err.sv
// Interrupt-enable set/clear registers, sticky event status and the
// receive error-source flags of a UART, behind an AXI4-Lite slave.
// Assumes event and receiver strobes are one-cycle pulses on i_clk;
// the serial input pin is asynchronous and is synchronised here.
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none

module uim_uart_irq_err (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire uim_pkg::uim_axi_req_type  i_axi,
  output var uim_pkg::uim_axi_resp_type  o_axi,
  input  wire logic [31:0]               i_evt,
  input  wire uim_pkg::uim_rx_stat_type  i_rx,
  input  wire logic                      i_rxd,
  output logic                           o_irq
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Expand byte strobes to a bit mask; used by every write path
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Read decode: hit flag and data
  function automatic logic [32:0] rd_decode(input logic [11:0] addr,
                                            input uim_pkg::uim_state_type s);
    case (addr)
      uim_pkg::OFS_EVT_STAT:  rd_decode = {1'b1, s.evt_stat};
      uim_pkg::OFS_INTEN_SET: rd_decode = {1'b1, s.inten};
      uim_pkg::OFS_INTEN_CLR: rd_decode = {1'b1, s.inten};
      uim_pkg::OFS_ERR_SRC:   rd_decode = {1'b1, s.err_src};
      default:                rd_decode = {1'b0, 32'h0000_0000};
    endcase
  endfunction

  uim_pkg::uim_state_type state_reg;
  uim_pkg::uim_state_type state_next;

  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_bits;
  logic [32:0] rd_hit_data;
  logic [31:0] err_set;
  logic [31:0] evt_set;
  logic [3:0]  frame_len;
  logic        rd_stat;

  // -----------------------------------------------------------------
  // Bus handshakes; one write and one read in flight at most
  // -----------------------------------------------------------------
  assign o_axi.awready = !state_reg.aw_got && !state_reg.bvalid;
  assign o_axi.wready  = !state_reg.w_got && !state_reg.bvalid;
  assign o_axi.bvalid  = state_reg.bvalid;
  assign o_axi.bresp   = state_reg.bresp;
  assign o_axi.arready = !state_reg.rvalid;
  assign o_axi.rvalid  = state_reg.rvalid;
  assign o_axi.rdata   = state_reg.rdata;
  assign o_axi.rresp   = state_reg.rresp;
  assign o_irq         = state_reg.irq;

  // Address and data may arrive in either order; commit once both held
  assign aw_take = i_axi.awvalid && o_axi.awready;
  assign w_take  = i_axi.wvalid && o_axi.wready;
  assign ar_take = i_axi.arvalid && o_axi.arready;
  assign wr_fire = (state_reg.aw_got || aw_take) && (state_reg.w_got || w_take);
  assign wr_addr = state_reg.aw_got ? state_reg.aw_addr : i_axi.awaddr;
  assign wr_bits = state_reg.w_got
                 ? (state_reg.w_data & lane_mask(state_reg.w_strb))
                 : (i_axi.wdata & lane_mask(i_axi.wstrb));
  assign rd_hit_data = rd_decode(i_axi.araddr, state_reg);
  assign rd_stat     = ar_take && (i_axi.araddr == uim_pkg::OFS_EVT_STAT);

  // -----------------------------------------------------------------
  // Receive error detection
  // -----------------------------------------------------------------
  assign frame_len = i_rx.parity_on ? uim_pkg::FRAME_BITS_PAR : uim_pkg::FRAME_BITS_NOPAR;

  always_comb begin
    err_set = 32'h0000_0000;
    // Byte still unread when the next start bit lands
    err_set[uim_pkg::ERR_OVERRUN_BIT] = i_rx.start_bit && i_rx.holding_full;
    // Parity only judged while the checker is switched on
    err_set[uim_pkg::ERR_PARITY_BIT]  = i_rx.char_done && i_rx.parity_on
                                        && i_rx.parity_bad;
    err_set[uim_pkg::ERR_FRAMING_BIT] = i_rx.char_done && i_rx.stop_bad;
    // One break per low stretch: brk_seen blocks repeats
    err_set[uim_pkg::ERR_BREAK_BIT]   = !state_reg.rxd_sync && i_rx.bit_tick
                                        && !state_reg.brk_seen
                                        && (state_reg.low_cnt >= frame_len);
  end

  // Events from the UART plus an error event whenever a flag fires
  always_comb begin
    evt_set = i_evt & uim_pkg::EVT_IMPL_MASK;
    evt_set[uim_pkg::EVT_ERROR_BIT] = i_evt[uim_pkg::EVT_ERROR_BIT] || (|err_set);
  end

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Pin synchroniser; only rxd_sync is looked at
    state_next.rxd_meta = i_rxd;
    state_next.rxd_sync = state_reg.rxd_meta;

    // Low-time counter in bit ticks, saturating above a frame
    if (state_reg.rxd_sync) begin
      state_next.low_cnt  = 4'h0;
      state_next.brk_seen = 1'b0;
    end else if (i_rx.bit_tick) begin
      if (state_reg.low_cnt != 4'hf) begin
        state_next.low_cnt = state_reg.low_cnt + 4'h1;
      end
      if (err_set[uim_pkg::ERR_BREAK_BIT]) begin
        state_next.brk_seen = 1'b1;
      end
    end

    // Write channel capture
    if (aw_take && !wr_fire) begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = i_axi.awaddr;
    end
    if (w_take && !wr_fire) begin
      state_next.w_got  = 1'b1;
      state_next.w_data = i_axi.wdata;
      state_next.w_strb = i_axi.wstrb;
    end
    if (state_reg.bvalid && i_axi.bready) begin
      state_next.bvalid = 1'b0;
    end

    // Error flags: write-one clears, a same-cycle detect wins
    state_next.err_src = state_reg.err_src;
    if (wr_fire && wr_addr == uim_pkg::OFS_ERR_SRC) begin
      state_next.err_src = state_reg.err_src & ~wr_bits;
    end
    state_next.err_src = (state_next.err_src | err_set) & uim_pkg::ERR_IMPL_MASK;

    // Commit a write and answer it
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = uim_pkg::RESP_OKAY;
      case (wr_addr)
        uim_pkg::OFS_INTEN_SET: begin
          state_next.inten = state_reg.inten | (wr_bits & uim_pkg::EVT_IMPL_MASK);
        end
        uim_pkg::OFS_INTEN_CLR: begin
          state_next.inten = state_reg.inten & ~wr_bits;
        end
        uim_pkg::OFS_ERR_SRC: begin
          state_next.bresp = uim_pkg::RESP_OKAY;
        end
        // Status is read-to-clear; writes are accepted and ignored
        uim_pkg::OFS_EVT_STAT: begin
          state_next.bresp = uim_pkg::RESP_OKAY;
        end
        default: begin
          state_next.bresp = uim_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read: data captured at the address handshake
    if (state_reg.rvalid && i_axi.rready) begin
      state_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_hit_data[31:0];
      state_next.rresp  = rd_hit_data[32] ? uim_pkg::RESP_OKAY : uim_pkg::RESP_SLVERR;
    end

    // Sticky events: a read clears, but a new event in that cycle stays
    state_next.evt_stat = (rd_stat ? 32'h0000_0000 : state_reg.evt_stat) | evt_set;

    // Level interrupt from next values so it tracks status with no lag
    state_next.irq = |(state_next.evt_stat & state_next.inten);
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg          <= '0;
      state_reg.inten    <= uim_pkg::INTEN_RESET;
      state_reg.err_src  <= uim_pkg::ERR_SRC_RESET;
      state_reg.evt_stat <= uim_pkg::EVT_STAT_RESET;
      state_reg.rxd_meta <= 1'b1;
      state_reg.rxd_sync <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_wr_set;
    wr_fire && wr_addr == uim_pkg::OFS_INTEN_SET;
  endsequence

  sequence s_wr_clr;
    wr_fire && wr_addr == uim_pkg::OFS_INTEN_CLR;
  endsequence

  chk_inten_set_on: assert property (
    s_wr_set |=> ((state_reg.inten & $past(wr_bits) & uim_pkg::EVT_IMPL_MASK)
                  == ($past(wr_bits) & uim_pkg::EVT_IMPL_MASK)))
    else $error("enable set write did not enable");

  chk_inten_read_back: assert property (
    ar_take && (i_axi.araddr == uim_pkg::OFS_INTEN_SET
                || i_axi.araddr == uim_pkg::OFS_INTEN_CLR)
    |=> o_axi.rvalid && o_axi.rdata == $past(state_reg.inten))
    else $error("enable read does not show enable state");

  chk_inten_clr_off: assert property (
    s_wr_clr |=> ((state_reg.inten & $past(wr_bits)) == 32'h0000_0000))
    else $error("enable clear write did not disable");

  chk_err_w1c: assert property (
    wr_fire && wr_addr == uim_pkg::OFS_ERR_SRC && err_set == 32'h0000_0000
    |=> state_reg.err_src == ($past(state_reg.err_src) & ~$past(wr_bits)))
    else $error("error flag write-one-clear wrong");

  chk_overrun_set: assert property (
    i_rx.start_bit && i_rx.holding_full |=> state_reg.err_src[uim_pkg::ERR_OVERRUN_BIT])
    else $error("overrun not flagged");

  chk_parity_set: assert property (
    i_rx.char_done && i_rx.parity_bad && !(wr_fire && wr_addr == uim_pkg::OFS_ERR_SRC)
    |=> state_reg.err_src[uim_pkg::ERR_PARITY_BIT] == ($past(i_rx.parity_on)
        || $past(state_reg.err_src[uim_pkg::ERR_PARITY_BIT])))
    else $error("parity flag wrong");

  chk_framing_set: assert property (
    i_rx.char_done && i_rx.stop_bad |=> state_reg.err_src[uim_pkg::ERR_FRAMING_BIT])
    else $error("framing not flagged");

  chk_break_wait: assert property (
    $rose(state_reg.err_src[uim_pkg::ERR_BREAK_BIT])
    |-> $past(state_reg.low_cnt) >= $past(frame_len) && !$past(state_reg.rxd_sync))
    else $error("break flagged before a whole frame");

  chk_irq_level: assert property (
    ##1 o_irq == (|(state_reg.evt_stat & state_reg.inten)))
    else $error("interrupt level disagrees with pending events");

endmodule // uim_uart_irq_err

`default_nettype wire

//--- verilog/uim_pkg.sv
// Constants, register map and carrier types of the UART interrupt-mask
// and receive-error block. Assumes a 32-bit AXI4-Lite register bus.
`default_nettype none

package uim_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W           = 12;
  localparam logic [11:0] OFS_EVT_STAT     = 12'h100;
  localparam logic [11:0] OFS_INTEN_SET    = 12'h304;
  localparam logic [11:0] OFS_INTEN_CLR    = 12'h308;
  localparam logic [11:0] OFS_ERR_SRC      = 12'h480;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  // Event bits 0,1,2,4,7,8,9,17,19,20,22
  localparam logic [31:0] EVT_IMPL_MASK    = 32'h005a_0397;
  localparam int unsigned EVT_ERROR_BIT    = 9;
  localparam int unsigned ERR_OVERRUN_BIT  = 0;
  localparam int unsigned ERR_PARITY_BIT   = 1;
  localparam int unsigned ERR_FRAMING_BIT  = 2;
  localparam int unsigned ERR_BREAK_BIT    = 3;
  localparam logic [31:0] ERR_IMPL_MASK    = 32'h0000_000f;
  localparam logic [31:0] INTEN_RESET      = 32'h0000_0000;
  localparam logic [31:0] ERR_SRC_RESET    = 32'h0000_0000;
  localparam logic [31:0] EVT_STAT_RESET   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Frame lengths in bit times, bus responses
  // ---------------------------------------------------------------
  localparam logic [3:0]  FRAME_BITS_NOPAR = 4'ha;
  localparam logic [3:0]  FRAME_BITS_PAR   = 4'hb;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } uim_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uim_axi_resp_type;

  // Strobes from the receiver, same clock as this block
  typedef struct packed {
    logic start_bit;
    logic holding_full;
    logic char_done;
    logic parity_bad;
    logic stop_bad;
    logic parity_on;
    logic bit_tick;
  } uim_rx_stat_type;

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       inten;
    logic [31:0]       err_src;
    logic [31:0]       evt_stat;
    logic              rxd_meta;
    logic              rxd_sync;
    logic [3:0]        low_cnt;
    logic              brk_seen;
    logic              irq;
  } uim_state_type;

endpackage

`default_nettype wire

//--- tb/uim_rx_partner.sv
// Remote serial transmitter model: holds the receive line low for a
// requested number of bit ticks and makes the receiver's bit tick.
// Assumes the same clock and synchronous reset as the block under test.
`default_nettype none

module uim_rx_partner (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_go,
  input  wire logic [4:0] i_low_ticks,
  output logic            o_rxd,
  output logic            o_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Bit timing and low stretch
  // ---------------------------------------------------------------
  logic [2:0] div_reg;
  logic [4:0] left_reg;
  logic       low_reg;

  // One tick every 8 cycles; line released right after the last tick
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_reg  <= 3'h0;
      left_reg <= 5'h00;
      low_reg  <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (i_go) begin
        low_reg  <= 1'b1;
        left_reg <= i_low_ticks;
      end else if (low_reg && o_tick) begin
        left_reg <= left_reg - 5'h01;
        if (left_reg == 5'h01) begin
          low_reg <= 1'b0;
        end
      end
    end
  end

  // Idle line is high, as a released UART line with pull-up
  assign o_tick = (div_reg == 3'h7);
  assign o_rxd  = ~low_reg;

endmodule // uim_rx_partner

`default_nettype wire

//--- tb/uim_uart_irq_err_tb.sv
// Self-checking bench: AXI4-Lite register tests, receive error flags,
// break detection through the partner model and the interrupt line.
// Assumes bready and rready may be held high for the whole run.
`default_nettype none

`define CHECK_EQ(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module uim_uart_irq_err_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam logic [11:0] SET = uim_pkg::OFS_INTEN_SET;
  localparam logic [11:0] CLR = uim_pkg::OFS_INTEN_CLR;
  localparam logic [11:0] ERR = uim_pkg::OFS_ERR_SRC;
  localparam logic [11:0] EVT = uim_pkg::OFS_EVT_STAT;
  localparam logic [1:0]  OK  = uim_pkg::RESP_OKAY;
  localparam logic [1:0]  BAD = uim_pkg::RESP_SLVERR;

  logic                      clk;
  logic                      reset_n;
  uim_pkg::uim_axi_req_type  req;
  uim_pkg::uim_axi_resp_type rsp;
  logic [31:0]               evt;
  logic [6:0]                rx_base;
  uim_pkg::uim_rx_stat_type  rx_in;
  logic                      rxd;
  logic                      tick;
  logic                      irq;
  logic                      go;
  logic [4:0]                lowt;
  logic [31:0]               rd_d;
  logic [1:0]                rd_r;
  int                        err_count;
  int                        checks_done;

  // Bit tick comes from the partner, all other receiver strobes from here
  assign rx_in = {rx_base[6:1], tick};

  uim_uart_irq_err uim_uart_irq_err_i (
    .i_clk     (clk),
    .i_reset_n (reset_n),
    .i_axi     (req),
    .o_axi     (rsp),
    .i_evt     (evt),
    .i_rx      (rx_in),
    .i_rxd     (rxd),
    .o_irq     (irq)
  );

  uim_rx_partner uim_rx_partner_i (
    .i_clk       (clk),
    .i_reset_n   (reset_n),
    .i_go        (go),
    .i_low_ticks (lowt),
    .o_rxd       (rxd),
    .o_tick      (tick)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w  = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    // Each channel released at its own handshake edge
    do begin
      @(posedge clk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (aw || w);
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    `CHECK_EQ(rsp.bresp, er)
  endtask

  task automatic rd(input logic [11:0] a);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    `CHECK_EQ(rd_d, e)
    `CHECK_EQ(rd_r, er)
  endtask

  // Levels holding_full and parity_on stay after the pulse
  task automatic rx_pulse(input logic [6:0] v);
    rx_base <= v;
    @(posedge clk);
    rx_base <= v & 7'h22;
    @(posedge clk);
  endtask

  task automatic evt_pulse(input logic [31:0] v);
    evt <= v;
    @(posedge clk);
    evt <= 32'h0;
    repeat (2) @(posedge clk);
  endtask

  // Start a low stretch right after a tick so it spans exactly n ticks
  task automatic brk(input logic [4:0] n);
    do @(posedge clk); while (tick !== 1'b1);
    go   <= 1'b1;
    lowt <= n;
    @(posedge clk);
    go <= 1'b0;
    repeat (8 * n + 24) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // Whole run is under a thousand cycles; watchdog is far beyond that
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end

  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    evt = 32'h0;
    rx_base = 7'h00;
    go = 1'b0;
    lowt = 5'h00;
    reset_n = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Enable registers and error flags
    rd_chk(SET, uim_pkg::INTEN_RESET, OK);
    rd_chk(CLR, uim_pkg::INTEN_RESET, OK);
    rd_chk(ERR, uim_pkg::ERR_SRC_RESET, OK);
    wr(SET, 32'hffff_ffff, OK);
    rd_chk(SET, uim_pkg::EVT_IMPL_MASK, OK);
    rd_chk(CLR, uim_pkg::EVT_IMPL_MASK, OK);
    wr(CLR, 32'h0058_0000, OK);
    wr(SET, 32'h0, OK);
    rd_chk(SET, uim_pkg::EVT_IMPL_MASK & ~32'h0058_0000, OK);
    rd_chk(CLR, uim_pkg::EVT_IMPL_MASK & ~32'h0058_0000, OK);
    wr(CLR, 32'hffff_ffff, OK);
    rd_chk(SET, 32'h0, OK);
    rd_chk(12'h200, 32'h0, BAD);
    wr(12'h200, 32'hffff_ffff, BAD);
    $display("test registers done");
    // Receive errors
    rx_pulse(7'h40);
    rd_chk(ERR, 32'h0, OK);
    rx_pulse(7'h60);
    rd_chk(ERR, 32'h1, OK);
    rx_pulse(7'h18);
    rd_chk(ERR, 32'h1, OK);
    rx_pulse(7'h1a);
    rd_chk(ERR, 32'h3, OK);
    rx_pulse(7'h14);
    rd_chk(ERR, 32'h7, OK);
    wr(ERR, 32'h0, OK);
    rd_chk(ERR, 32'h7, OK);
    wr(ERR, 32'h1, OK);
    rd_chk(ERR, 32'h6, OK);
    wr(ERR, 32'h6, OK);
    rd_chk(ERR, 32'h0, OK);
    $display("test errors done");
    // Break, without and with parity
    for (int p = 0; p < 2; p++) begin
      rx_base <= (p == 1) ? 7'h02 : 7'h00;
      // One whole frame stays quiet, one tick more is a break
      brk(5'd10 + 5'(p));
      rd_chk(ERR, 32'h0, OK);
      brk(5'd11 + 5'(p));
      rd_chk(ERR, 32'h8, OK);
      wr(ERR, 32'h8, OK);
    end
    rx_base <= 7'h00;
    rd_chk(ERR, 32'h0, OK);
    $display("test break done");
    // Interrupt line
    rd(EVT);
    repeat (2) @(posedge clk);
    `CHECK_EQ(irq, 1'b0)
    evt_pulse(32'h0040_0000);
    `CHECK_EQ(irq, 1'b0)
    wr(SET, 32'h0040_0000, OK);
    repeat (2) @(posedge clk);
    `CHECK_EQ(irq, 1'b1)
    wr(CLR, 32'h0040_0000, OK);
    repeat (2) @(posedge clk);
    `CHECK_EQ(irq, 1'b0)
    wr(SET, 32'h0040_0000, OK);
    // A write to the status word must leave pending events alone
    wr(EVT, 32'hffff_ffff, OK);
    `CHECK_EQ(irq, 1'b1)
    rd_chk(EVT, 32'h0040_0000, OK);
    repeat (2) @(posedge clk);
    `CHECK_EQ(irq, 1'b0)
    evt_pulse(32'h0040_0000);
    `CHECK_EQ(irq, 1'b1)
    $display("test interrupt done");
    tally_and_finish;
  end

endmodule // uim_uart_irq_err_tb

`undef CHECK_EQ

`default_nettype wire
